// ==== rtl/flash_prot_pkg.sv ====
// constants for the flash status and page protection block
// assumes one core clock domain and a byte-addressed register port

package flash_prot_pkg;

    // ---------------------------------------------------------------
    // register port geometry
    // ---------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          OFS_W        = 7;
    localparam int          PAGE_W       = 7;
    localparam int          NUM_BLOCKS   = 2;

    // ---------------------------------------------------------------
    // register offsets within one block window
    // ---------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_STATUS = 7'h00;
    localparam logic [OFS_W-1:0] OFS_MODE   = 7'h04;
    localparam logic [OFS_W-1:0] OFS_KEY    = 7'h14;
    localparam logic [OFS_W-1:0] OFS_PRO    = 7'h1c;
    localparam logic [OFS_W-1:0] OFS_HID    = 7'h20;

    // ---------------------------------------------------------------
    // status and mode fields
    // ---------------------------------------------------------------
    localparam int          STA_DONE_BIT    = 0;
    localparam int          STA_FAIL_BIT    = 1;
    localparam int          STA_BUSY_BIT    = 2;
    localparam int          STA_IRQ_BIT     = 3;
    localparam int          STA_W           = 16;
    localparam int          MODE_W          = 8;
    localparam int          MODE_IRQ_EN_BIT = 4;

    // ---------------------------------------------------------------
    // reset values and key
    // ---------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET    = 8'h80;
    localparam logic [DATA_W-1:0] PRO_RESET     = 32'h00000000;
    localparam logic [DATA_W-1:0] HID_RESET     = 32'h0fffffff;
    // key value is arbitrary
    localparam logic [DATA_W-1:0] PRO_KEY_VALUE = 32'h00005a5a;

    // ---------------------------------------------------------------
    // protection field layout
    // ---------------------------------------------------------------
    localparam int               READ_PROT_BIT    = 31;
    localparam int               B1_TOP_GROUP_BIT = 30;
    localparam int               PAGE_GROUP_SHIFT = 2;
    localparam logic [PAGE_W-1:0] B0_LAST_PAGE    = 7'h7b;
    localparam logic [PAGE_W-1:0] B1_TOP_PAGE     = 7'h78;

endpackage

// ==== rtl/flash_block_regs.sv ====
// status, mode, key and protection registers of one flash block
// assumes offsets already decoded for this block and same-clock inputs

`timescale 1ns/10ps

module flash_block_regs
    import flash_prot_pkg::*;
(
    // clock and resets
    input  wire logic              core_clk_i,
    input  wire logic              reset_i,
    input  wire logic              por_i,
    // register access
    input  wire logic              sel_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [OFS_W-1:0]  ofs_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o,
    // controller events
    input  wire logic              cmd_done_i,
    input  wire logic              cmd_fail_i,
    input  wire logic              ctrl_busy_i,
    // protection state and interrupt flag
    output logic      [DATA_W-1:0] prot_o,
    output logic                   irq_flag_o
);

    typedef struct packed {
        logic              done;
        logic              fail;
        logic              busy;
        logic              irq;
        logic [MODE_W-1:0] mode;
        logic              key_ok;
        logic [DATA_W-1:0] pro;
        logic [DATA_W-1:0] active;
        logic [DATA_W-1:0] hid;
    } blk_state_t;

    blk_state_t st_reg;
    blk_state_t st_next;
    logic       rd_sta;
    logic       wr_hit;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        rd_sta  = sel_i && rd_i && (ofs_i == OFS_STATUS);
        wr_hit  = sel_i && wr_i;
        if (rd_sta)
        begin
            st_next.done = 1'b0;
            st_next.fail = 1'b0;
            st_next.irq  = 1'b0;
        end
        if (cmd_done_i)
        begin
            st_next.done = 1'b1;
            if (st_reg.mode[MODE_IRQ_EN_BIT])
            begin
                st_next.irq = 1'b1;
            end
            if (cmd_fail_i)
            begin
                st_next.fail = 1'b1;
            end
        end
        st_next.busy = ctrl_busy_i;
        if (wr_hit)
        begin
            st_next.key_ok = 1'b0;
            case (ofs_i)
                OFS_MODE: st_next.mode = wdata_i[MODE_W-1:0];
                OFS_KEY:  st_next.key_ok = (wdata_i == PRO_KEY_VALUE);
                OFS_PRO:
                begin
                    if (st_reg.key_ok)
                    begin
                        st_next.pro = wdata_i;
                    end
                end
                OFS_HID:  st_next.hid = wdata_i;
                default:  st_next.key_ok = 1'b0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (por_i)
        begin
            st_reg <= '{done: 1'b0, fail: 1'b0, busy: 1'b0, irq: 1'b0,
                        mode: MODE_RESET, key_ok: 1'b0, pro: PRO_RESET,
                        active: PRO_RESET, hid: HID_RESET};
        end
        else if (reset_i)
        begin
            st_reg.done   <= 1'b0;
            st_reg.fail   <= 1'b0;
            st_reg.busy   <= 1'b0;
            st_reg.irq    <= 1'b0;
            st_reg.mode   <= MODE_RESET;
            st_reg.key_ok <= 1'b0;
            st_reg.active <= st_reg.pro;
            st_reg.hid    <= HID_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // read data and protection view
    // ---------------------------------------------------------------
    always_comb
    begin
        rdata_o = '0;
        case (ofs_i)
            OFS_STATUS:
            begin
                rdata_o[STA_DONE_BIT] = st_reg.done;
                rdata_o[STA_FAIL_BIT] = st_reg.fail;
                rdata_o[STA_BUSY_BIT] = st_reg.busy;
                rdata_o[STA_IRQ_BIT]  = st_reg.irq;
            end
            OFS_MODE: rdata_o[MODE_W-1:0] = st_reg.mode;
            OFS_PRO:  rdata_o = st_reg.pro;
            OFS_HID:  rdata_o = st_reg.hid;
            default:  rdata_o = '0;
        endcase
    end

    assign prot_o     = st_reg.active & st_reg.hid;
    assign irq_flag_o = st_reg.irq;

endmodule

// ==== rtl/flash_status_protect.sv ====
// flash status reporting and page protection for two flash blocks
// assumes a same-clock register port and same-clock controller signals

`timescale 1ns/10ps

// Contract
// - command end with enable sets flag; read clears
// - busy bit follows controller activity
// - failed command sets fail; read clears
// - completed command sets done; read clears
// - block0 bit31 low blocks reads
// - block0 bits30:0 guard four-page groups
// - block1 bit31 low blocks reads
// - block1 bit30 guards pages 120-127
// - block1 bits29:0 guard four-page groups
// - keyed persistent protection applies after reset
// - immediate protection applies at once
module flash_status_protect
    import flash_prot_pkg::*;
(
    // clock and resets
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  por_i,
    // register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [DATA_W-1:0]     reg_wdata_i,
    output logic      [DATA_W-1:0]     reg_rdata_o,
    output logic                       reg_rvalid_o,
    // controller events per block
    input  wire logic [NUM_BLOCKS-1:0] cmd_done_i,
    input  wire logic [NUM_BLOCKS-1:0] cmd_fail_i,
    input  wire logic [NUM_BLOCKS-1:0] ctrl_busy_i,
    // access check
    input  wire logic                  acc_valid_i,
    input  wire logic                  acc_write_i,
    input  wire logic                  acc_block_i,
    input  wire logic [PAGE_W-1:0]     acc_page_i,
    output logic                       acc_grant_o,
    output logic                       acc_deny_o,
    // status flags
    output logic [NUM_BLOCKS-1:0]      irq_flag_o
);

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              grant;
        logic              deny;
    } top_state_t;

    top_state_t                        st_reg;
    top_state_t                        st_next;
    logic       [DATA_W-1:0]           blk_rdata [NUM_BLOCKS];
    logic       [DATA_W-1:0]           blk_prot  [NUM_BLOCKS];
    logic       [NUM_BLOCKS-1:0]       blk_irq;
    logic                              addr_blk;
    logic       [OFS_W-1:0]            addr_ofs;

    assign addr_blk = reg_addr_i[ADDR_W-1];
    assign addr_ofs = reg_addr_i[OFS_W-1:0];

    // ---------------------------------------------------------------
    // per-block registers
    // ---------------------------------------------------------------
    generate
        for (genvar b = 0; b < NUM_BLOCKS; b++)
        begin : g_blk
            flash_block_regs u_regs (
                .core_clk_i  (core_clk_i),
                .reset_i     (reset_i),
                .por_i       (por_i),
                .sel_i       (addr_blk == 1'(b)),
                .wr_i        (reg_wr_i),
                .rd_i        (reg_rd_i),
                .ofs_i       (addr_ofs),
                .wdata_i     (reg_wdata_i),
                .rdata_o     (blk_rdata[b]),
                .cmd_done_i  (cmd_done_i[b]),
                .cmd_fail_i  (cmd_fail_i[b]),
                .ctrl_busy_i (ctrl_busy_i[b]),
                .prot_o      (blk_prot[b]),
                .irq_flag_o  (blk_irq[b])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // page permission decode
    // ---------------------------------------------------------------
    function automatic logic page_ok(input logic              blk,
                                     input logic              wr,
                                     input logic [PAGE_W-1:0] page,
                                     input logic [DATA_W-1:0] prot);
        logic [PAGE_W-1:0] grp;
        logic              ok;
        grp = page >> PAGE_GROUP_SHIFT;
        ok  = 1'b1;
        if (!wr)
        begin
            ok = prot[READ_PROT_BIT];
        end
        else if (!blk)
        begin
            if (page <= B0_LAST_PAGE)
            begin
                ok = prot[grp[4:0]];
            end
        end
        else if (page >= B1_TOP_PAGE)
        begin
            ok = prot[B1_TOP_GROUP_BIT];
        end
        else
        begin
            ok = prot[grp[4:0]];
        end
        return ok;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next        = st_reg;
        st_next.rvalid = reg_rd_i;
        st_next.rdata  = reg_rd_i ? blk_rdata[addr_blk] : '0;
        st_next.grant  = 1'b0;
        st_next.deny   = 1'b0;
        if (acc_valid_i)
        begin
            if (page_ok(acc_block_i, acc_write_i, acc_page_i, blk_prot[acc_block_i]))
            begin
                st_next.grant = 1'b1;
            end
            else
            begin
                st_next.deny = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || por_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata_o  = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign acc_grant_o  = st_reg.grant;
    assign acc_deny_o   = st_reg.deny;
    assign irq_flag_o   = blk_irq;

endmodule

// ==== dv/flash_status_protect_assertions.sv ====
// checker for the flash status and page protection block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps

module flash_status_protect_assertions
    import flash_prot_pkg::*;
(
    // clock and resets
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  por_i,
    // register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [DATA_W-1:0]     reg_rdata_o,
    input  wire logic                  reg_rvalid_o,
    // controller events, access check, flags
    input  wire logic [NUM_BLOCKS-1:0] cmd_done_i,
    input  wire logic [NUM_BLOCKS-1:0] ctrl_busy_i,
    input  wire logic                  acc_valid_i,
    input  wire logic                  acc_grant_o,
    input  wire logic                  acc_deny_o,
    input  wire logic [NUM_BLOCKS-1:0] irq_flag_o
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i || por_i);

    property p_irq_set;
        $rose(irq_flag_o[0]) |-> $past(cmd_done_i[0]);
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt flag rose without a finished command");
    property p_irq_clr0;
        (reg_rd_i && reg_addr_i == 8'h00 && !cmd_done_i[0]) |=> !irq_flag_o[0];
    endproperty
    a_irq_clr0: assert property (p_irq_clr0)
        else $error("block 0 interrupt flag kept after status read");
    property p_irq_clr1;
        (reg_rd_i && reg_addr_i == 8'h80 && !cmd_done_i[1]) |=> !irq_flag_o[1];
    endproperty
    a_irq_clr1: assert property (p_irq_clr1)
        else $error("block 1 interrupt flag kept after status read");
    property p_busy;
        (reg_rd_i && reg_addr_i == 8'h00)
            |=> reg_rdata_o[STA_BUSY_BIT] == $past(ctrl_busy_i[0], 2);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy bit does not follow the controller");
    property p_flags_clr;
        (reg_rd_i && reg_addr_i == 8'h00 && !cmd_done_i[0]) ##1
            (reg_rd_i && reg_addr_i == 8'h00) |=> reg_rdata_o[1:0] == 2'h0;
    endproperty
    a_flags_clr: assert property (p_flags_clr)
        else $error("done or fail survived a status read");
    property p_reserved;
        (reg_rd_i && reg_addr_i[OFS_W-1:0] == OFS_STATUS)
            |=> reg_rvalid_o && reg_rdata_o[15:4] == 12'h000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("status read without answer or with reserved bits set");
    property p_acc_answer;
        acc_valid_i |=> acc_grant_o != acc_deny_o;
    endproperty
    a_acc_answer: assert property (p_acc_answer)
        else $error("access check not answered by exactly one of grant or deny");
    property p_acc_quiet;
        !acc_valid_i |=> !acc_grant_o && !acc_deny_o;
    endproperty
    a_acc_quiet: assert property (p_acc_quiet)
        else $error("grant or deny without a request");
endmodule

bind flash_status_protect flash_status_protect_assertions flash_status_protect_assertions_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .por_i(por_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .cmd_done_i(cmd_done_i), .ctrl_busy_i(ctrl_busy_i),
    .acc_valid_i(acc_valid_i), .acc_grant_o(acc_grant_o), .acc_deny_o(acc_deny_o),
    .irq_flag_o(irq_flag_o)
);

// ==== dv/flash_status_protect_tb.sv ====
// self-checking bench for the flash status and page protection block
// assumes the checker is bound separately and one 50 MHz core clock
`timescale 1ns/10ps

module flash_status_protect_tb
    import flash_prot_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic                  core_clk_i  = 1'h0;
    logic                  reset_i     = 1'h1;
    logic                  por_i       = 1'h1;
    logic [ADDR_W-1:0]     reg_addr_i  = 8'h00;
    logic                  reg_wr_i    = 1'h0;
    logic                  reg_rd_i    = 1'h0;
    logic [DATA_W-1:0]     reg_wdata_i = 32'h0;
    logic [DATA_W-1:0]     reg_rdata_o;
    logic                  reg_rvalid_o;
    logic [NUM_BLOCKS-1:0] cmd_done_i  = 2'h0;
    logic [NUM_BLOCKS-1:0] cmd_fail_i  = 2'h0;
    logic [NUM_BLOCKS-1:0] ctrl_busy_i = 2'h0;
    logic                  acc_valid_i = 1'h0;
    logic                  acc_write_i = 1'h0;
    logic                  acc_block_i = 1'h0;
    logic [PAGE_W-1:0]     acc_page_i  = 7'h00;
    logic                  acc_grant_o;
    logic                  acc_deny_o;
    logic [NUM_BLOCKS-1:0] irq_flag_o;
    int                    num_errors  = 0;
    int                    num_checks  = 0;
    int                    cycles      = 0;

    flash_status_protect flash_status_protect_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .por_i(por_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .cmd_done_i(cmd_done_i), .cmd_fail_i(cmd_fail_i), .ctrl_busy_i(ctrl_busy_i),
        .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_block_i(acc_block_i),
        .acc_page_i(acc_page_i), .acc_grant_o(acc_grant_o), .acc_deny_o(acc_deny_o),
        .irq_flag_o(irq_flag_o)
    );

    initial
    begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset(input logic p);
        reset_i <= 1'h1;
        por_i   <= p;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'h0;
        por_i   <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'h1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'h1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        check({31'h0, reg_rvalid_o}, 32'h1);
        check(reg_rdata_o, exp);
    endtask

    task automatic rd_pair(input logic [7:0] a, input logic [31:0] e0, input logic [31:0] e1);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'h1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        #1;
        check(reg_rdata_o, e0);
        @(posedge core_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        check({31'h0, reg_rvalid_o}, 32'h1);
        check(reg_rdata_o, e1);
    endtask

    task automatic cmd(input logic [1:0] m, input logic f);
        @(posedge core_clk_i);
        cmd_done_i <= m;
        cmd_fail_i <= f ? m : 2'h0;
        @(posedge core_clk_i);
        cmd_done_i <= 2'h0;
        cmd_fail_i <= 2'h0;
        #1;
    endtask

    task automatic acc(input logic b, input logic w, input logic [6:0] p, input logic g);
        @(posedge core_clk_i);
        acc_valid_i <= 1'h1;
        acc_block_i <= b;
        acc_write_i <= w;
        acc_page_i  <= p;
        @(posedge core_clk_i);
        acc_valid_i <= 1'h0;
        #1;
        check({30'h0, acc_grant_o, acc_deny_o}, {30'h0, g, !g});
    endtask

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        do_reset(1'h1);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h80);
        rd(8'h20, 32'h0fffffff);
        rd(8'h1c, 32'h0);
        acc(1'h0, 1'h0, 7'h00, 1'h0);
        wr(8'h04, 32'h90);
        cmd(2'h1, 1'h1);
        check({30'h0, irq_flag_o}, 32'h1);
        wr(8'h00, 32'hffffffff);
        rd(8'h00, 32'h0000000b);
        check({30'h0, irq_flag_o}, 32'h0);
        rd(8'h00, 32'h0);
        cmd(2'h2, 1'h0);
        check({30'h0, irq_flag_o}, 32'h0);
        rd(8'h80, 32'h1);
        cmd(2'h1, 1'h1);
        rd_pair(8'h00, 32'h0000000b, 32'h0);
        wr(8'h84, 32'h90);
        cmd(2'h2, 1'h0);
        check({30'h0, irq_flag_o}, 32'h2);
        rd(8'h80, 32'h9);
        @(posedge core_clk_i);
        ctrl_busy_i <= 2'h3;
        rd(8'h80, 32'h4);
        rd(8'h00, 32'h4);
        @(posedge core_clk_i);
        ctrl_busy_i <= 2'h0;
        rd(8'h80, 32'h0);
        wr(8'h14, PRO_KEY_VALUE);
        wr(8'h1c, 32'hffffffff);
        wr(8'h94, PRO_KEY_VALUE);
        wr(8'h9c, 32'hffffffff);
        wr(8'h1c, 32'h0);
        rd(8'h1c, 32'hffffffff);
        acc(1'h0, 1'h1, 7'h00, 1'h0);
        @(posedge core_clk_i);
        do_reset(1'h0);
        acc(1'h0, 1'h0, 7'h00, 1'h0);
        acc(1'h0, 1'h1, 7'h00, 1'h1);
        wr(8'h20, 32'hffffffdf);
        acc(1'h0, 1'h1, 7'h13, 1'h1);
        acc(1'h0, 1'h1, 7'h14, 1'h0);
        acc(1'h0, 1'h1, 7'h17, 1'h0);
        acc(1'h0, 1'h1, 7'h18, 1'h1);
        acc(1'h0, 1'h0, 7'h14, 1'h1);
        wr(8'h20, 32'hbfffffff);
        acc(1'h0, 1'h1, 7'h7b, 1'h0);
        acc(1'h0, 1'h1, 7'h77, 1'h1);
        wr(8'h20, 32'h7fffffff);
        acc(1'h0, 1'h0, 7'h05, 1'h0);
        acc(1'h0, 1'h1, 7'h05, 1'h1);
        wr(8'ha0, 32'hbfffffff);
        acc(1'h1, 1'h1, 7'h78, 1'h0);
        acc(1'h1, 1'h1, 7'h7f, 1'h0);
        acc(1'h1, 1'h1, 7'h77, 1'h1);
        acc(1'h1, 1'h0, 7'h7f, 1'h1);
        wr(8'ha0, 32'hfffffffe);
        acc(1'h1, 1'h1, 7'h03, 1'h0);
        acc(1'h1, 1'h1, 7'h04, 1'h1);
        acc(1'h1, 1'h1, 7'h78, 1'h1);
        wr(8'ha0, 32'hdfffffff);
        acc(1'h1, 1'h1, 7'h74, 1'h0);
        wr(8'ha0, 32'h7fffffff);
        acc(1'h1, 1'h0, 7'h00, 1'h0);
        print_verdict();
    end
endmodule
